// ---- logic/dual_timer_defines.svh ----
// Purpose: Offsets, field positions, reset values and timing counts of the dual timer block
// Assumes: Register indices are word indices; byte address is four times the index
// Notes:   Definitions only
//
// Overview of operation
// - Interrupt-1 select 0 means low level active, 1 means falling edge active.
// - Interrupt-0 flag set on falling pin edge, cleared on vectoring acknowledge in edge mode; in level mode it follows the inverted pin.
// - Interrupt-0 select 0 means low level active, 1 means falling edge active.
// - Timer 1 runs on run bit; with gating also needs interrupt-1 pin high.
// - Timer 1 counts every two clocks, or on count pin falling edges.
// - Timer 1 mode 00: high byte counts through five-bit low prescaler.
// - Timer 1 modes: 01 sixteen-bit, 10 eight-bit reload from high, 11 stopped.
// - Timer 0 runs on run bit; with gating also needs interrupt-0 pin high.
// - Timer 0 counts every two clocks, or on count pin falling edges.
// - Timer 0 modes 00, 01, 10: prescaled, sixteen-bit, eight-bit auto-reload.
// - Timer 0 mode 11: split low byte; high byte uses timer 1 run and flag.
// - All four count bytes are read/write and reset to zero.
// - Timer 1 overflow flag set on overflow, cleared on vectoring acknowledge.
// - Timer 0 overflow flag set on overflow, cleared on vectoring acknowledge.
// - Timer 1 run bit: one lets timer 1 count, zero halts it.
// - Interrupt-1 flag set on falling pin edge, cleared on vectoring acknowledge in edge mode; in level mode it follows the inverted pin.
`ifndef DUAL_TIMER_DEFINES_SVH
`define DUAL_TIMER_DEFINES_SVH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define IDX_CTRL      8'h88
`define IDX_MODE      8'h89
`define IDX_TA_LO     8'h8A
`define IDX_TB_LO     8'h8B
`define IDX_TA_HI     8'h8C
`define IDX_TB_HI     8'h8D

// ----------------------------------------
// Control register bit positions
// ----------------------------------------
`define CTRL_B_OVF    7
`define CTRL_B_RUN    6
`define CTRL_A_OVF    5
`define CTRL_A_RUN    4
`define CTRL_XB_FLAG  3
`define CTRL_XB_TRIG  2
`define CTRL_XA_FLAG  1
`define CTRL_XA_TRIG  0

// ----------------------------------------
// Mode register fields
// ----------------------------------------
`define MODE_B_GATE   7
`define MODE_B_CSEL   6
`define MODE_B_MHI    5
`define MODE_B_MLO    4
`define MODE_A_GATE   3
`define MODE_A_CSEL   2
`define MODE_A_MHI    1
`define MODE_A_MLO    0

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define RST_BYTE      8'h00
`define RST_TIMER_AND_EXTINT_CONTROL      8'h00
`define TICK_DIV      2

`endif

// ---- logic/dual_timer_pkg.sv ----
// Purpose: Types shared by the dual timer block
// Assumes: Nothing
// Notes:   Mode codes follow the two-bit mode fields
package dual_timer_pkg;

  typedef enum logic [1:0] {
    MODE_PRESCALED = 2'b00,
    MODE_16BIT     = 2'b01,
    MODE_RELOAD    = 2'b10,
    MODE_SPLIT     = 2'b11
  } timer_mode_t;

endpackage

// ---- logic/timer_core.sv ----
// Purpose: One timer's count pair with the four counting modes
// Assumes: cnt_en and hi_en are one-cycle count steps from the parent
// Notes:   A software write to a byte wins over counting of that byte
`timescale 1ns/1ps
`include "dual_timer_defines.svh"

module timer_core (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire dual_timer_pkg::timer_mode_t mode,
  input  wire logic                       cnt_en,
  input  wire logic                       hi_en,
  input  wire logic                       wr_lo,
  input  wire logic                       wr_hi,
  input  wire logic [7:0]                 wdata,
  output logic      [7:0]                 count_lo,
  output logic      [7:0]                 count_hi,
  output logic                            ovf,
  output logic                            ovf_hi
);

  logic [7:0] lo_d;
  logic [7:0] hi_d;
  logic [8:0] c_lo;
  logic [8:0] c_hi;

  function automatic logic [8:0] inc8(input logic [7:0] v);
    return {1'b0, v} + 9'h001;
  endfunction

  always_comb begin
    lo_d   = count_lo;
    hi_d   = count_hi;
    ovf    = 1'b0;
    ovf_hi = 1'b0;
    c_lo   = inc8(count_lo);
    c_hi   = inc8(count_hi);
    case (mode)
      dual_timer_pkg::MODE_PRESCALED: begin
        // Upper three low bits are left alone, as they are no part of the count
        if (cnt_en) begin
          if (count_lo[4:0] == 5'h1F) begin
            lo_d = {count_lo[7:5], 5'h00};
            hi_d = c_hi[7:0];
            ovf  = c_hi[8];
          end else begin
            lo_d = {count_lo[7:5], c_lo[4:0]};
          end
        end
      end
      dual_timer_pkg::MODE_16BIT: begin
        if (cnt_en) begin
          lo_d = c_lo[7:0];
          if (c_lo[8]) begin
            hi_d = c_hi[7:0];
          end
          ovf = c_lo[8] & c_hi[8];
        end
      end
      dual_timer_pkg::MODE_RELOAD: begin
        if (cnt_en) begin
          if (c_lo[8]) begin
            lo_d = count_hi;
            ovf  = 1'b1;
          end else begin
            lo_d = c_lo[7:0];
          end
        end
      end
      dual_timer_pkg::MODE_SPLIT: begin
        if (cnt_en) begin
          lo_d = c_lo[7:0];
          ovf  = c_lo[8];
        end
        if (hi_en) begin
          hi_d   = c_hi[7:0];
          ovf_hi = c_hi[8];
        end
      end
      default: begin
        lo_d = count_lo;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_lo <= `RST_BYTE;
      count_hi <= `RST_BYTE;
    end else begin
      count_lo <= wr_lo ? wdata : lo_d;
      count_hi <= wr_hi ? wdata : hi_d;
    end
  end

endmodule // timer_core

// ---- logic/dual_timer_counter_extint.sv ----
// Purpose: Two timer/counters and external interrupt edge/level control behind APB
// Assumes: Pins synchronous to pclk; ack inputs are one-cycle vectoring pulses
// Notes:   One wait state on every APB access; read data is taken one cycle early
`timescale 1ns/1ps
`include "dual_timer_defines.svh"

module dual_timer_counter_extint #(
  parameter int ADDR_W = 12
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              extint_a_pin,
  input  wire logic              extint_b_pin,
  input  wire logic              timer_a_count_pin,
  input  wire logic              timer_b_count_pin,
  input  wire logic              ack_timer_a,
  input  wire logic              ack_timer_b,
  input  wire logic              ack_extint_a,
  input  wire logic              ack_extint_b,
  output logic                   timer_a_overflow_flag,
  output logic                   timer_b_overflow_flag,
  output logic                   extint_a_flag,
  output logic                   extint_b_flag
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  // Byte addresses reach 0x234, so ten address bits are the least
  if (ADDR_W < 10) begin : g_addr_check
    $error("ADDR_W must be at least 10");
  end

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [7:0]                  timer_mode_control_q;
  logic                        timer_a_run_q;
  logic                        timer_b_run_q;
  logic                        extint_a_trigger_select_q;
  logic                        extint_b_trigger_select_q;
  logic                        xa_pin_q;
  logic                        xb_pin_q;
  logic                        ca_pin_q;
  logic                        cb_pin_q;
  logic                        div_q;
  logic                        tick;
  logic                        wr_fire;
  logic [7:0]                  idx;
  logic                        hit;
  logic [7:0]                  rd_byte;
  logic [7:0]                  timer_and_extint_control;
  logic [7:0]                  wbyte;
  dual_timer_pkg::timer_mode_t timer_a_mode_field;
  dual_timer_pkg::timer_mode_t timer_b_mode_field;
  logic                        timer_a_gating;
  logic                        timer_b_gating;
  logic                        timer_a_count_select;
  logic                        timer_b_count_select;
  logic                        en_a;
  logic                        en_b;
  logic                        step_a;
  logic                        step_b;
  logic                        hi_step_a;
  logic                        fall_xa;
  logic                        fall_xb;
  logic                        fall_ca;
  logic                        fall_cb;
  logic [7:0]                  ta_lo;
  logic [7:0]                  ta_hi;
  logic [7:0]                  tb_lo;
  logic [7:0]                  tb_hi;
  logic                        ovf_a;
  logic                        ovf_a_hi;
  logic                        ovf_b;
  logic                        set_b_ovf;
  logic                        wr_ctrl;
  logic                        wr_ta_lo;
  logic                        wr_ta_hi;
  logic                        wr_tb_lo;
  logic                        wr_tb_hi;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [7:0] i);
    return a == ADDR_W'({i, 2'b00});
  endfunction

  assign wr_fire  = psel & penable & pready & pwrite;
  assign wbyte    = pwdata[7:0];
  assign wr_ctrl  = wr_fire & addr_hit(paddr, `IDX_CTRL);
  assign wr_ta_lo = wr_fire & addr_hit(paddr, `IDX_TA_LO);
  assign wr_ta_hi = wr_fire & addr_hit(paddr, `IDX_TA_HI);
  assign wr_tb_lo = wr_fire & addr_hit(paddr, `IDX_TB_LO);
  assign wr_tb_hi = wr_fire & addr_hit(paddr, `IDX_TB_HI);

  assign timer_and_extint_control = {timer_b_overflow_flag, timer_b_run_q,
                                     timer_a_overflow_flag, timer_a_run_q,
                                     extint_b_flag, extint_b_trigger_select_q,
                                     extint_a_flag, extint_a_trigger_select_q};

  always_comb begin
    idx     = paddr[9:2];
    hit     = 1'b1;
    rd_byte = 8'h00;
    if (paddr != ADDR_W'({idx, 2'b00})) begin
      hit = 1'b0;
    end else begin
      case (idx)
        `IDX_CTRL:  rd_byte = timer_and_extint_control;
        `IDX_MODE:  rd_byte = timer_mode_control_q;
        `IDX_TA_LO: rd_byte = ta_lo;
        `IDX_TB_LO: rd_byte = tb_lo;
        `IDX_TA_HI: rd_byte = ta_hi;
        `IDX_TB_HI: rd_byte = tb_hi;
        default:    hit = 1'b0;
      endcase
    end
  end

  // One wait state keeps read data and error coming straight from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      prdata  <= {24'h00_0000, pwrite ? 8'h00 : rd_byte};
      pslverr <= ~hit;
    end else begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------
  // Mode and control bits
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_mode_control_q <= `RST_BYTE;
    end else if (wr_fire && addr_hit(paddr, `IDX_MODE)) begin
      timer_mode_control_q <= wbyte;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_a_run_q             <= 1'b0;
      timer_b_run_q             <= 1'b0;
      extint_a_trigger_select_q <= 1'b0;
      extint_b_trigger_select_q <= 1'b0;
    end else if (wr_ctrl) begin
      timer_a_run_q             <= wbyte[`CTRL_A_RUN];
      timer_b_run_q             <= wbyte[`CTRL_B_RUN];
      extint_a_trigger_select_q <= wbyte[`CTRL_XA_TRIG];
      extint_b_trigger_select_q <= wbyte[`CTRL_XB_TRIG];
    end
  end

  assign timer_a_mode_field   = dual_timer_pkg::timer_mode_t'(
                                  timer_mode_control_q[`MODE_A_MHI:`MODE_A_MLO]);
  assign timer_b_mode_field   = dual_timer_pkg::timer_mode_t'(
                                  timer_mode_control_q[`MODE_B_MHI:`MODE_B_MLO]);
  assign timer_a_gating       = timer_mode_control_q[`MODE_A_GATE];
  assign timer_b_gating       = timer_mode_control_q[`MODE_B_GATE];
  assign timer_a_count_select = timer_mode_control_q[`MODE_A_CSEL];
  assign timer_b_count_select = timer_mode_control_q[`MODE_B_CSEL];

  // ----------------------------------------
  // Pin history and the two-clock tick
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xa_pin_q <= 1'b1;
      xb_pin_q <= 1'b1;
      ca_pin_q <= 1'b1;
      cb_pin_q <= 1'b1;
    end else begin
      xa_pin_q <= extint_a_pin;
      xb_pin_q <= extint_b_pin;
      ca_pin_q <= timer_a_count_pin;
      cb_pin_q <= timer_b_count_pin;
    end
  end

  assign fall_xa = xa_pin_q & ~extint_a_pin;
  assign fall_xb = xb_pin_q & ~extint_b_pin;
  assign fall_ca = ca_pin_q & ~timer_a_count_pin;
  assign fall_cb = cb_pin_q & ~timer_b_count_pin;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 1'b0;
    end else begin
      div_q <= (div_q == 1'(`TICK_DIV - 1)) ? 1'b0 : div_q + 1'b1;
    end
  end

  assign tick = (div_q == 1'(`TICK_DIV - 1));

  // ----------------------------------------
  // Run gating and count steps
  // ----------------------------------------
  assign en_a   = timer_a_run_q & (~timer_a_gating | extint_a_pin);
  assign en_b   = timer_b_run_q & (~timer_b_gating | extint_b_pin);
  assign step_a = en_a & (timer_a_count_select ? fall_ca : tick);
  // Mode 11 stops timer 1 outright
  assign step_b = en_b & (timer_b_count_select ? fall_cb : tick)
                & (timer_b_mode_field != dual_timer_pkg::MODE_SPLIT);
  // Split high byte is a pure timer, run by timer 1's run bit
  assign hi_step_a = (timer_a_mode_field == dual_timer_pkg::MODE_SPLIT)
                   & timer_b_run_q & tick;

  timer_core u_timer_a (
    .pclk     (pclk),
    .presetn  (presetn),
    .mode     (timer_a_mode_field),
    .cnt_en   (step_a),
    .hi_en    (hi_step_a),
    .wr_lo    (wr_ta_lo),
    .wr_hi    (wr_ta_hi),
    .wdata    (wbyte),
    .count_lo (ta_lo),
    .count_hi (ta_hi),
    .ovf      (ovf_a),
    .ovf_hi   (ovf_a_hi)
  );

  timer_core u_timer_b (
    .pclk     (pclk),
    .presetn  (presetn),
    .mode     (timer_b_mode_field),
    .cnt_en   (step_b),
    .hi_en    (1'b0),
    .wr_lo    (wr_tb_lo),
    .wr_hi    (wr_tb_hi),
    .wdata    (wbyte),
    .count_lo (tb_lo),
    .count_hi (tb_hi),
    .ovf      (ovf_b),
    .ovf_hi   ()
  );

  // ----------------------------------------
  // Overflow flags
  // ----------------------------------------
  // While timer 0 is split, its high byte owns timer 1's flag
  assign set_b_ovf = (timer_a_mode_field == dual_timer_pkg::MODE_SPLIT) ? ovf_a_hi : ovf_b;

  // Hardware set wins over a software clear or an acknowledge in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_a_overflow_flag <= 1'b0;
    end else if (ovf_a) begin
      timer_a_overflow_flag <= 1'b1;
    end else if (wr_ctrl) begin
      timer_a_overflow_flag <= wbyte[`CTRL_A_OVF];
    end else if (ack_timer_a) begin
      timer_a_overflow_flag <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_b_overflow_flag <= 1'b0;
    end else if (set_b_ovf) begin
      timer_b_overflow_flag <= 1'b1;
    end else if (wr_ctrl) begin
      timer_b_overflow_flag <= wbyte[`CTRL_B_OVF];
    end else if (ack_timer_b) begin
      timer_b_overflow_flag <= 1'b0;
    end
  end

  // ----------------------------------------
  // External interrupt flags
  // ----------------------------------------
  // Level mode ignores writes and acks: the flag only follows the inverted pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      extint_a_flag <= 1'b0;
    end else if (!extint_a_trigger_select_q) begin
      extint_a_flag <= ~extint_a_pin;
    end else if (fall_xa) begin
      extint_a_flag <= 1'b1;
    end else if (wr_ctrl) begin
      extint_a_flag <= wbyte[`CTRL_XA_FLAG];
    end else if (ack_extint_a) begin
      extint_a_flag <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      extint_b_flag <= 1'b0;
    end else if (!extint_b_trigger_select_q) begin
      extint_b_flag <= ~extint_b_pin;
    end else if (fall_xb) begin
      extint_b_flag <= 1'b1;
    end else if (wr_ctrl) begin
      extint_b_flag <= wbyte[`CTRL_XB_FLAG];
    end else if (ack_extint_b) begin
      extint_b_flag <= 1'b0;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  level_b_follow_a: assert property (
    !extint_b_trigger_select_q && !$past(wr_ctrl) ##1 !extint_b_trigger_select_q
      |-> extint_b_flag == !$past(extint_b_pin))
    else $error("level flag b does not follow pin");

  edge_a_set_a: assert property (
    extint_a_trigger_select_q && xa_pin_q && !extint_a_pin |=> extint_a_flag)
    else $error("falling edge did not set flag a");

  ack_a_clear_a: assert property (
    extint_a_trigger_select_q && ack_extint_a && !fall_xa && !wr_ctrl |=> !extint_a_flag)
    else $error("ack did not clear flag a");

  gate_b_hold_a: assert property (
    timer_b_gating && !extint_b_pin && !wr_tb_lo && !wr_tb_hi |=> $stable({tb_hi, tb_lo}))
    else $error("gated timer b moved with pin low");

  tick_alt_a: assert property (
    tick |=> !tick ##1 tick)
    else $error("tick not every two clocks");

  run16_a_step_a: assert property (
    en_a && !timer_a_count_select && tick && !wr_ta_lo && !wr_ta_hi
      && timer_a_mode_field == dual_timer_pkg::MODE_16BIT
      |=> {ta_hi, ta_lo} == 16'($past({ta_hi, ta_lo}) + 16'h0001))
    else $error("timer a sixteen bit step wrong");

  reload_a_a: assert property (
    step_a && ta_lo == 8'hFF && !wr_ta_lo && !wr_ctrl
      && timer_a_mode_field == dual_timer_pkg::MODE_RELOAD
      |=> ta_lo == $past(ta_hi) && timer_a_overflow_flag)
    else $error("timer a reload or flag wrong");

  stop_b_a: assert property (
    timer_b_mode_field == dual_timer_pkg::MODE_SPLIT && !wr_tb_lo && !wr_tb_hi
      |=> $stable({tb_hi, tb_lo}))
    else $error("timer b moved in mode 11");

  run_a_off_a: assert property (
    !timer_a_run_q && !wr_ta_lo |=> $stable(ta_lo))
    else $error("timer a low moved while halted");

  split_flag_a: assert property (
    hi_step_a && ta_hi == 8'hFF && !wr_ta_hi |=> timer_b_overflow_flag && ta_hi == 8'h00)
    else $error("split high overflow missed flag b");

endmodule // dual_timer_counter_extint

// ---- tb/pin_model.sv ----
// Purpose: Far-side pins: interrupt inputs and count inputs
// Assumes: Driven just after the rising edge of pclk
// Notes:   Pins rest high between pulses
`timescale 1ns/1ps
module pin_model (
  input  wire logic pclk,
  output logic      extint_a_pin,
  output logic      extint_b_pin,
  output logic      timer_a_count_pin,
  output logic      timer_b_count_pin
);
  initial begin
    extint_a_pin      = 1'b1;
    extint_b_pin      = 1'b1;
    timer_a_count_pin = 1'b1;
    timer_b_count_pin = 1'b1;
  end

  task automatic set_int(input int w, input logic v);
    if (w == 0) extint_a_pin <= v;
    else extint_b_pin <= v;
    @(posedge pclk);
  endtask

  // Two cycles low and two high, so every edge is sampled
  task automatic pulse(input int w, input int n);
    repeat (n) begin
      if (w == 0) timer_a_count_pin <= 1'b0;
      else timer_b_count_pin <= 1'b0;
      repeat (2) @(posedge pclk);
      if (w == 0) timer_a_count_pin <= 1'b1;
      else timer_b_count_pin <= 1'b1;
      repeat (2) @(posedge pclk);
    end
  endtask
endmodule // pin_model

// ---- tb/dual_timer_counter_extint_tb.sv ----
// Purpose: Self-checking bench for the dual timer block
// Assumes: One wait state per APB access; pins driven by pin_model
// Notes:   Reads are checked by a monitor against a queue of notes
`timescale 1ns/1ps
module dual_timer_counter_extint_tb;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr;
  logic [3:0]  acks;
  wire  [3:0]  flags;
  wire         xa, xb, ca, cb;
  logic [32:0] exp_q[$];
  int          fail_count, tests_run, seed;
  logic [7:0]  v;

  pin_model pins (.pclk(pclk), .extint_a_pin(xa), .extint_b_pin(xb),
    .timer_a_count_pin(ca), .timer_b_count_pin(cb));
  dual_timer_counter_extint dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .extint_a_pin(xa), .extint_b_pin(xb),
    .timer_a_count_pin(ca), .timer_b_count_pin(cb), .ack_extint_a(acks[0]),
    .ack_extint_b(acks[1]), .ack_timer_a(acks[2]), .ack_timer_b(acks[3]),
    .extint_a_flag(flags[0]), .extint_b_flag(flags[1]),
    .timer_a_overflow_flag(flags[2]), .timer_b_overflow_flag(flags[3]));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic check_flag(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s exp %b got %b", nm, e, g);
    end
  endtask

  task automatic check_rd(input logic [32:0] e, input logic [32:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] read exp %h got %h", e, g);
    end
  endtask

  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      check_rd(exp_q.pop_front(), {pslverr, prdata});
    end
  end

  // Read notes its expectation; the byte address is four times the index
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                     input logic slv = 1'b0);
    int n;
    if (!wr) exp_q.push_back({slv, 24'h0, wd});
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'h0, idx, 2'h0};
    pwdata  <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      $display("[ERR] pready exp 1 got %b", pready);
      end_of_test();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wait_flag(input int b, input int lo, input int hi);
    int n;
    n = 0;
    while (flags[b] !== 1'b1 && n < hi) begin
      @(posedge pclk);
      n++;
    end
    check_flag("flag_time", 1'b1, flags[b] === 1'b1 && n >= lo);
    if (flags[b] !== 1'b1) end_of_test();
  endtask

  task automatic ack(input int b);
    acks[b] <= 1'b1;
    @(posedge pclk);
    acks <= 4'h0;
    repeat (2) @(posedge pclk);
  endtask

  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial begin
    seed = 32'hF752;
    fail_count = 0;
    tests_run = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    acks = 4'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 8'h88; i <= 8'h8D; i++) apb(0, 8'(i), 8'h00);
    apb(0, 8'h90, 8'h00, 1'b1);
    for (int i = 8'h8A; i <= 8'h8D; i++) begin
      v = 8'($random(seed));
      apb(1, 8'(i), v);
      apb(0, 8'(i), v);
    end
    apb(1, 8'h89, 8'h05);
    apb(1, 8'h8A, 8'hFE);
    apb(1, 8'h8C, 8'h00);
    apb(1, 8'h88, 8'h10);
    pins.pulse(0, 3);
    apb(0, 8'h8A, 8'h01);
    apb(0, 8'h8C, 8'h01);
    apb(1, 8'h88, 8'h00);
    pins.pulse(0, 2);
    apb(0, 8'h8A, 8'h01);
    apb(1, 8'h89, 8'h0D);
    apb(1, 8'h88, 8'h11);
    pins.set_int(0, 1'b0);
    @(posedge pclk);
    check_flag("xa_edge", 1'b1, flags[0]);
    ack(0);
    check_flag("xa_ack", 1'b0, flags[0]);
    pins.pulse(0, 2);
    apb(0, 8'h8A, 8'h01);
    pins.set_int(0, 1'b1);
    pins.pulse(0, 2);
    apb(0, 8'h8A, 8'h03);
    apb(1, 8'h89, 8'h60);
    apb(1, 8'h8B, 8'hFE);
    apb(1, 8'h8D, 8'hF0);
    apb(1, 8'h88, 8'h40);
    pins.pulse(1, 3);
    apb(0, 8'h8B, 8'hF1);
    check_flag("tb_ovf", 1'b1, flags[3]);
    ack(3);
    check_flag("tb_ack", 1'b0, flags[3]);
    apb(1, 8'h89, 8'h40);
    apb(1, 8'h8B, 8'h3F);
    apb(1, 8'h8D, 8'h07);
    pins.pulse(1, 1);
    apb(0, 8'h8B, 8'h20);
    apb(0, 8'h8D, 8'h08);
    apb(1, 8'h89, 8'h70);
    pins.pulse(1, 2);
    apb(0, 8'h8B, 8'h20);
    apb(1, 8'h89, 8'hD0);
    pins.set_int(1, 1'b0);
    @(posedge pclk);
    check_flag("xb_level", 1'b1, flags[1]);
    pins.pulse(1, 2);
    apb(0, 8'h8B, 8'h20);
    pins.set_int(1, 1'b1);
    @(posedge pclk);
    check_flag("xb_follow", 1'b0, flags[1]);
    apb(1, 8'h88, 8'h04);
    pins.set_int(1, 1'b0);
    @(posedge pclk);
    check_flag("xb_edge", 1'b1, flags[1]);
    ack(1);
    check_flag("xb_ack", 1'b0, flags[1]);
    pins.set_int(1, 1'b1);
    apb(1, 8'h88, 8'h00);
    pins.pulse(1, 2);
    apb(0, 8'h8B, 8'h20);
    apb(1, 8'h89, 8'h01);
    apb(1, 8'h8A, 8'hF0);
    apb(1, 8'h8C, 8'hFF);
    apb(1, 8'h88, 8'h10);
    wait_flag(2, 26, 40);
    ack(2);
    check_flag("ta_ack", 1'b0, flags[2]);
    apb(1, 8'h8C, 8'hFF);
    apb(1, 8'h89, 8'h03);
    apb(1, 8'h88, 8'h40);
    wait_flag(3, 0, 8);
    check_flag("ta_split", 1'b0, flags[2]);
    end_of_test();
  end
endmodule // dual_timer_counter_extint_tb
